// >>> boce_exec.sv
// Execution unit for add-with-carry, and-literal, negate, call via accumulator, indexed move
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
module boce_exec
   import boce_pkg::*;
#(
   parameter int DMEM_DEPTH = 4096
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   // Complete state of the block
   typedef struct packed {
      boce_fsm_t fsm;
      boce_kind_t kind;
      logic [31:0] instr;
      logic [7:0] acc;
      logic [ST_W-1:0] status;
      logic [3:0] bank;
      logic [PC_W-1:0] pc;
      logic [7:0] latch_high;
      logic [4:0] latch_upper;
      logic [DATA_AW-1:0] ptr2;
      logic [PC_W-1:0] return_stack_top;
      logic ext_en;
      logic [DATA_AW-1:0] dmem_addr;
      logic [DATA_AW-1:0] op_addr;
      logic mem_pend;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } boce_state_t;

   // All-zero reset leaves the sequencer idle and the bus quiet
   localparam boce_state_t STATE_RESET = '0;

   boce_state_t st; // Registered state
   boce_state_t next_st; // Next state
   logic mem_we; // Memory write strobe
   logic [DATA_AW-1:0] mem_addr; // Memory address
   logic [7:0] mem_wdata; // Memory write byte
   logic [7:0] mem_rdata; // Memory read byte, one cycle after address
   boce_alu_in_t alu_in; // Adder operands
   boce_alu_out_t alu_out; // Adder result and flags
   logic apb_access; // Access phase present
   logic apb_done; // Transfer completes at this edge
   logic [DATA_AW-1:0] f_addr; // Resolved register operand address
   logic [DATA_AW-1:0] src_addr; // Indexed move source address
   logic [7:0] f_field; // Register operand field
   logic [7:0] and_res; // And-literal result

   // Data space
   boce_dmem #(
      .AW(DATA_AW),
      .DEPTH(DMEM_DEPTH)
   ) u_dmem (
      .clock(CLOCK),
      .we(mem_we),
      .addr(mem_addr),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   // Shared adder for add with carry and negate
   boce_alu u_alu (
      .a_in(alu_in),
      .a_out(alu_out)
   );

   // Register read multiplexer; unmapped offsets read zero
   function automatic logic [31:0] read_word(input boce_state_t s, input logic [7:0] a,
                                             input logic [7:0] md);
      logic [31:0] w;
      w = '0;
      case (a)
         REG_INSTR: begin
            w = s.instr;
         end
         REG_ACC: begin
            w[7:0] = s.acc;
         end
         REG_STATUS: begin
            w[ST_W-1:0] = s.status;
         end
         REG_BANK: begin
            w[3:0] = s.bank;
         end
         REG_PC: begin
            w[PC_W-1:0] = s.pc;
         end
         REG_LATCH: begin
            w[12:0] = {s.latch_upper, s.latch_high};
         end
         REG_PTR2: begin
            w[DATA_AW-1:0] = s.ptr2;
         end
         REG_STACK: begin
            w[PC_W-1:0] = s.return_stack_top;
         end
         REG_CTRL: begin
            w[CTRL_EXT] = s.ext_en;
         end
         REG_DMEM_ADDR: begin
            w[DATA_AW-1:0] = s.dmem_addr;
         end
         REG_DMEM_DATA: begin
            w[7:0] = md;
         end
         REG_EXEC: begin
            w[2:0] = s.fsm;
         end
         default: begin
            w = '0;
         end
      endcase
      return w;
   endfunction

   // Offset decode, true for every mapped register
   function automatic logic is_mapped(input logic [7:0] a);
      logic hit;
      hit = 1'b0;
      case (a)
         REG_INSTR, REG_ACC, REG_STATUS, REG_BANK, REG_PC, REG_LATCH, REG_PTR2,
         REG_STACK, REG_CTRL, REG_DMEM_ADDR, REG_DMEM_DATA, REG_EXEC: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
      return hit;
   endfunction

   // Operand address resolution for byte-oriented register instructions
   always_comb begin
      f_field = st.instr[7:0];
      if (st.instr[BIT_BANK]) begin
         f_addr = {st.bank, f_field};
      end else if (st.ext_en && (f_field <= IDX_LIMIT)) begin
         f_addr = st.ptr2 + {4'h0, f_field};
      end else if (f_field <= IDX_LIMIT) begin
         // Lower access half maps onto bank zero
         f_addr = {4'h0, f_field};
      end else begin
         // Upper access half maps onto the special registers
         f_addr = {ACCESS_HIGH_BANK, f_field};
      end
      // pointer two plus unsigned seven-bit offset
      src_addr = st.ptr2 + {5'h00, st.instr[6:0]};
      // plain bitwise and with the literal
      and_res = st.acc & st.instr[7:0];
   end

   // Next-state logic: bus slave first, then the sequencer
   always_comb begin
      next_st = st;
      mem_we = 1'b0;
      mem_addr = st.dmem_addr;
      mem_wdata = PWDATA[7:0];
      alu_in.x = st.acc;
      alu_in.y = mem_rdata;
      alu_in.cin = st.status[ST_C];
      apb_access = PSEL && PENABLE;
      apb_done = apb_access && st.pready;

      // Bus side: the slave only answers while the sequencer is idle,
      // which stalls software instead of letting it race an instruction
      if (apb_done) begin
         next_st.pready = 1'b0;
         next_st.pslverr = 1'b0;
         next_st.mem_pend = 1'b0;
         // Writes take effect only at the completing edge
         if (PWRITE && !st.pslverr) begin
            case (PADDR)
               REG_INSTR: begin
                  next_st.instr = PWDATA;
                  next_st.fsm = S_DECODE;
               end
               REG_ACC: begin
                  next_st.acc = PWDATA[7:0];
               end
               REG_STATUS: begin
                  next_st.status = PWDATA[ST_W-1:0];
               end
               REG_BANK: begin
                  next_st.bank = PWDATA[3:0];
               end
               REG_PC: begin
                  next_st.pc = PWDATA[PC_W-1:0];
               end
               REG_LATCH: begin
                  next_st.latch_high = PWDATA[7:0];
                  next_st.latch_upper = PWDATA[12:8];
               end
               REG_PTR2: begin
                  next_st.ptr2 = PWDATA[DATA_AW-1:0];
               end
               REG_CTRL: begin
                  next_st.ext_en = PWDATA[CTRL_EXT];
               end
               REG_DMEM_ADDR: begin
                  next_st.dmem_addr = PWDATA[DATA_AW-1:0];
               end
               REG_DMEM_DATA: begin
                  mem_we = 1'b1;
               end
               default: begin
                  next_st.fsm = st.fsm;
               end
            endcase
         end
      end else if (apb_access && (st.fsm == S_IDLE)) begin
         if (!PWRITE && (PADDR == REG_DMEM_DATA) && !st.mem_pend) begin
            // Memory read needs one extra cycle for its registered output
            next_st.mem_pend = 1'b1;
         end else begin
            next_st.pready = 1'b1;
            next_st.pslverr = !is_mapped(PADDR);
            next_st.prdata = PWRITE ? 32'h00000000 : read_word(st, PADDR, mem_rdata);
         end
      end

      // Sequencer
      case (st.fsm)
         S_IDLE: begin
            next_st.kind = K_NONE;
         end
         S_DECODE: begin
            if (st.instr[15:10] == OPC_ADDC) begin
               // fetch the register operand for the sum
               mem_addr = f_addr;
               next_st.op_addr = f_addr;
               next_st.kind = K_ADDC;
               next_st.fsm = S_EXEC;
            end else if (st.instr[15:9] == OPC_NEG) begin
               mem_addr = f_addr;
               next_st.op_addr = f_addr;
               next_st.kind = K_NEG;
               next_st.fsm = S_EXEC;
            end else if (st.instr[15:8] == OPC_AND) begin
               // accumulator result, negative and zero only
               next_st.acc = and_res;
               next_st.status[ST_N] = and_res[7];
               next_st.status[ST_Z] = (and_res == 8'h00);
               next_st.pc = st.pc + PC_STEP;
               next_st.fsm = S_IDLE;
            end else if (st.instr[15:0] == OPC_CALL) begin
               next_st.return_stack_top = st.pc + PC_STEP;
               // high and upper bytes from the latches
               // accumulator, status and bank are not touched
               next_st.pc = {st.latch_upper, st.latch_high, st.acc};
               next_st.fsm = S_CALL_NOP;
            end else if ((st.instr[15:7] == OPC_MOVS) && (st.instr[31:28] == OPC_MOVS_W2)) begin
               // source read in the first cycle
               mem_addr = src_addr;
               next_st.op_addr = st.instr[16+DATA_AW-1:16];
               next_st.kind = K_MOVS;
               next_st.fsm = S_EXEC;
            end else begin
               // Anything else retires as a no-operation
               next_st.pc = st.pc + PC_STEP;
               next_st.fsm = S_IDLE;
            end
         end
         S_EXEC: begin
            mem_addr = st.op_addr;
            if (st.kind == K_MOVS) begin
               // destination written in the second cycle
               mem_we = 1'b1;
               mem_wdata = mem_rdata;
               next_st.pc = st.pc + PC_STEP_TWO_WORDS;
            end else begin
               if (st.kind == K_NEG) begin
                  alu_in.x = ~mem_rdata;
                  alu_in.y = 8'h00;
                  alu_in.cin = 1'b1;
               end
               // all five flags follow the sum
               next_st.status = alu_out.flags;
               // negate always writes memory; for add the destination bit picks memory or accumulator
               if ((st.kind == K_NEG) || st.instr[BIT_DEST]) begin
                  mem_we = 1'b1;
                  mem_wdata = alu_out.res;
               end else begin
                  next_st.acc = alu_out.res;
               end
               next_st.pc = st.pc + PC_STEP;
            end
            next_st.kind = K_NONE;
            next_st.fsm = S_IDLE;
         end
         S_CALL_NOP: begin
            // idle second cycle while the target is fetched
            next_st.fsm = S_IDLE;
         end
         default: begin
            next_st.fsm = S_IDLE;
         end
      endcase
   end

   // Single state register, synchronous reset
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st <= STATE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Bus outputs straight from the state register
   assign PRDATA = st.prdata;
   assign PREADY = st.pready;
   assign PSLVERR = st.pslverr;

endmodule

// >>> boce_pkg.sv
// Shared constants and carrier types for the byte-op and call execution block
package boce_pkg;

   // Register map, byte addresses on the APB side
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_BANK = 8'h0C;
   localparam logic [7:0] REG_PC = 8'h10;
   localparam logic [7:0] REG_LATCH = 8'h14;
   localparam logic [7:0] REG_PTR2 = 8'h18;
   localparam logic [7:0] REG_STACK = 8'h1C;
   localparam logic [7:0] REG_CTRL = 8'h20;
   localparam logic [7:0] REG_DMEM_ADDR = 8'h24;
   localparam logic [7:0] REG_DMEM_DATA = 8'h28;
   localparam logic [7:0] REG_EXEC = 8'h2C;

   // Data space and program counter widths
   localparam int DATA_AW = 12;
   localparam int PC_W = 21;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [20:0] PC_STEP_TWO_WORDS = 21'h000004;

   // Opcode match values
   localparam logic [5:0] OPC_ADDC = 6'h08;
   localparam logic [6:0] OPC_NEG = 7'h36;
   localparam logic [7:0] OPC_AND = 8'h0B;
   localparam logic [15:0] OPC_CALL = 16'h0014;
   localparam logic [8:0] OPC_MOVS = 9'h1D6;
   localparam logic [3:0] OPC_MOVS_W2 = 4'hF;

   // Instruction field positions
   localparam int BIT_DEST = 9;
   localparam int BIT_BANK = 8;

   // Access bank split and indexed literal limit
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

   // Status bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   localparam int ST_OV = 3;
   localparam int ST_N = 4;
   localparam int ST_W = 5;

   // Control register bit
   localparam int CTRL_EXT = 0;

   // Execution sequencer states
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DECODE = 3'b001,
      S_EXEC = 3'b010,
      S_CALL_NOP = 3'b011
   } boce_fsm_t;

   // Instruction kinds held across cycles
   typedef enum logic [2:0] {
      K_NONE = 3'b000,
      K_ADDC = 3'b001,
      K_NEG = 3'b010,
      K_MOVS = 3'b011
   } boce_kind_t;

   // Adder operands and result
   typedef struct packed {
      logic [7:0] x;
      logic [7:0] y;
      logic cin;
   } boce_alu_in_t;

   typedef struct packed {
      logic [7:0] res;
      logic [4:0] flags;
   } boce_alu_out_t;

endpackage

// >>> boce_alu.sv
// Eight-bit adder with full status flag generation
`timescale 1ns/1ns
module boce_alu
   import boce_pkg::*;
(
   input wire boce_alu_in_t a_in,
   output boce_alu_out_t a_out
);

   // Nibble and byte partial sums
   logic [4:0] low_sum;
   logic [8:0] full_sum;

   // Sum and flags; negate is fed as inverted operand plus carry in
   always_comb begin
      low_sum = {1'b0, a_in.x[3:0]} + {1'b0, a_in.y[3:0]} + {4'h0, a_in.cin};
      full_sum = {1'b0, a_in.x} + {1'b0, a_in.y} + {8'h00, a_in.cin};
      a_out.res = full_sum[7:0];
      a_out.flags = '0;
      a_out.flags[ST_C] = full_sum[8];
      a_out.flags[ST_DC] = low_sum[4];
      a_out.flags[ST_Z] = (full_sum[7:0] == 8'h00);
      // Signed overflow: like-signed operands giving the other sign
      a_out.flags[ST_OV] = (a_in.x[7] == a_in.y[7]) && (full_sum[7] != a_in.x[7]);
      a_out.flags[ST_N] = full_sum[7];
   end

endmodule

// >>> boce_dmem.sv
// Byte-wide data space memory with registered read data
`timescale 1ns/1ns
module boce_dmem #(
   parameter int AW = 12,
   parameter int DEPTH = 4096
) (
   input wire logic clock,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);

   // Storage array
   logic [7:0] mem [DEPTH];

   // Write and registered read share one address; read sees old data
   always_ff @(posedge clock) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end

endmodule

// >>> boce_exec_sva.sv
// Port checker for the execution block's register bus
`timescale 1ns/1ns
module boce_exec_sva
   import boce_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR
);
   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   // Aligned word inside the map
   logic mapped;
   assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= REG_EXEC);
   // Access phase opens
   sequence s_start;
      $rose(PENABLE);
   endsequence
   // One-cycle answer
   sequence s_answer;
      PREADY ##1 !PREADY;
   endsequence
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
   a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE)) else $error("stray ready");
   // Busy sequencer delays the answer by a bounded amount
   a_ready_bound: assert property (s_start |-> ##[1:6] s_answer) else $error("no answer");
   a_unmapped_err: assert property (PREADY && !mapped |-> PSLVERR) else $error("no error");
   a_mapped_ok: assert property (PREADY && mapped |-> !PSLVERR) else $error("false error");
   a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error alone");
   a_err_zero: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("err data");
   a_rdata_hold: assert property ($changed(PRDATA) |-> PREADY) else $error("data moved");
   // Memory read needs one extra cycle
   a_dmem_slow: assert property (s_start ##0 (!PWRITE && PADDR == REG_DMEM_DATA)
      |-> !PREADY ##1 !PREADY) else $error("memory read early");
endmodule

bind boce_exec boce_exec_sva boce_exec_sva_i (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR));

// >>> boce_fetch_model.sv
// Bus master standing in for the fetch stage
`timescale 1ns/1ns
module boce_fetch_model (
   input wire logic clock,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   // Idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   // One transfer, held until ready is seen at an edge or for at most 20 edges
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e, output logic ok);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      ok = (pready === 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released bus shows stale-looking garbage, not the old data
      pwdata <= ~d;
   endtask
endmodule

// >>> byte_op_and_call_exec_test.sv
// Self-checking bench for the byte-op and call execution block
`timescale 1ns/1ns
module byte_op_and_call_exec_test
   import boce_pkg::*;
;
   logic CLOCK = 1'b0;
   logic RST = 1'b1;
   logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, last_err;
   logic [7:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   int fails = 0;
   int check_count = 0;
   // 100 MHz
   always #5 CLOCK = ~CLOCK;
   boce_exec #(.DMEM_DEPTH(4096)) boce_exec_i (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));
   boce_fetch_model boce_fetch_model_i (.clock(CLOCK), .prdata(PRDATA), .pready(PREADY),
      .pslverr(PSLVERR), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
      .paddr(PADDR), .pwdata(PWDATA));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   // Counts busy sequencer edges after an instruction write; the bus alone cannot see them
   task automatic busy(input logic [31:0] exp);
      int n;
      n = 0;
      @(posedge CLOCK);
      while (boce_exec_i.st.fsm != S_IDLE && n < 8) begin
         n++;
         @(posedge CLOCK);
      end
      chk(n, exp);
   endtask
   // Bus access; a lost answer counts as a mismatch
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] v);
      logic ok;
      boce_fetch_model_i.xfer(w, a, d, v, last_err, ok);
      chk({31'h0, ok}, 32'h1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      acc(1'b1, a, d, v);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      acc(1'b0, a, 32'h0, v);
      chk(v, exp);
   endtask
   task automatic mset(input logic [11:0] a, input logic [7:0] d);
      wr(REG_DMEM_ADDR, {20'h0, a});
      wr(REG_DMEM_DATA, {24'h0, d});
   endtask
   task automatic mchk(input logic [11:0] a, input logic [7:0] exp);
      wr(REG_DMEM_ADDR, {20'h0, a});
      rc(REG_DMEM_DATA, {24'h0, exp});
   endtask
   task automatic t_addc();
      mset(12'h010, 8'h02);
      wr(REG_ACC, 32'h4D);
      wr(REG_STATUS, 32'h01);
      wr(REG_INSTR, 32'h2010);
      rc(REG_ACC, 32'h50);
      rc(REG_STATUS, 32'h02);
      mchk(12'h010, 8'h02);
      // Banked target, result to memory, carry out and zero
      wr(REG_BANK, 32'h3);
      mset(12'h320, 8'hFF);
      wr(REG_ACC, 32'h01);
      wr(REG_STATUS, 32'h00);
      wr(REG_INSTR, 32'h2320);
      mchk(12'h320, 8'h00);
      rc(REG_ACC, 32'h01);
      rc(REG_STATUS, 32'h07);
   endtask
   task automatic t_neg();
      wr(REG_CTRL, 32'h1);
      wr(REG_PTR2, 32'h200);
      mset(12'h205, 8'h00);
      mset(12'h005, 8'h5A);
      wr(REG_INSTR, 32'h6C05);
      mchk(12'h205, 8'h00);
      mchk(12'h005, 8'h5A);
      rc(REG_STATUS, 32'h07);
      // High half of the access bank
      mset(12'hF80, 8'h3A);
      wr(REG_INSTR, 32'h6C80);
      mchk(12'hF80, 8'hC6);
      rc(REG_STATUS, 32'h10);
   endtask
   task automatic t_and();
      wr(REG_ACC, 32'hA3);
      wr(REG_STATUS, 32'h1F);
      wr(REG_INSTR, 32'h0B5F);
      busy(1);
      rc(REG_ACC, 32'h03);
      rc(REG_STATUS, 32'h0B);
   endtask
   task automatic t_call();
      wr(REG_PC, 32'h100);
      wr(REG_LATCH, 32'h0110);
      wr(REG_ACC, 32'h06);
      wr(REG_STATUS, 32'h15);
      wr(REG_BANK, 32'h5);
      wr(REG_INSTR, 32'h0014);
      busy(2);
      rc(REG_STACK, 32'h102);
      rc(REG_PC, 32'h011006);
      rc(REG_EXEC, 32'h0);
      rc(REG_ACC, 32'h06);
      rc(REG_STATUS, 32'h15);
      rc(REG_BANK, 32'h5);
      // Second call with a full upper latch and a new low byte
      wr(REG_LATCH, 32'h1FAB);
      wr(REG_ACC, 32'hC4);
      wr(REG_INSTR, 32'h0014);
      rc(REG_STACK, 32'h011008);
      rc(REG_PC, 32'h1FABC4);
   endtask
   task automatic t_movs();
      wr(REG_PC, 32'h40);
      wr(REG_PTR2, 32'h006);
      mset(12'h085, 8'h33);
      mset(12'hE23, 8'h00);
      // Second word without its marker retires as a no-operation
      wr(REG_INSTR, 32'h0E23EB7F);
      busy(1);
      mchk(12'hE23, 8'h00);
      rc(REG_PC, 32'h42);
      wr(REG_INSTR, 32'hFE23EB7F);
      busy(2);
      mchk(12'hE23, 8'h33);
      rc(REG_PC, 32'h46);
   endtask
   // Unmapped, unaligned and read-only places
   task automatic t_bus();
      rc(8'h30, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      rc(8'h02, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      wr(REG_STACK, 32'h1FFFFF);
      rc(REG_STACK, 32'h011008);
      wr(REG_BANK, 32'hFFFFFFFF);
      rc(REG_BANK, 32'hF);
   endtask
   // Reset in mid-run clears the registers but keeps data memory
   task automatic t_reset();
      @(posedge CLOCK);
      RST <= 1'b1;
      repeat (2) @(posedge CLOCK);
      RST <= 1'b0;
      rc(REG_STACK, 32'h0);
      rc(REG_PC, 32'h0);
      rc(REG_ACC, 32'h0);
      rc(REG_LATCH, 32'h0);
      rc(REG_CTRL, 32'h0);
      mchk(12'hE23, 8'h33);
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge CLOCK);
      RST <= 1'b0;
      t_addc();
      t_neg();
      t_and();
      t_call();
      t_movs();
      t_bus();
      t_reset();
      conclude();
   end
   // Watchdog, far beyond the 86 transfers of the run
   initial begin
      #200000;
      fails++;
      conclude();
   end
endmodule
